// ---- rtl/ccdr_ctrl.sv ----
/*
  Readout timing generator: drives image, storage, serial, multiplier and
  reset gates, the CDS strobes, and streams digitised pixels through a FIFO.
  Assumes ADC_DATA is asynchronous to CLK and settled when sample_signal is high.
*/
`timescale 1ns/10ps
`default_nettype none
module ccdr_ctrl #(
  parameter int FRAME_CYC = ccdr_pkg::FRAME_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RUN,
  input wire logic INTERLACE,
  input wire logic PIX_SUM,
  input wire logic MULT_EN,
  input wire logic [15:0] EXPOSURE_US,
  input wire logic [ccdr_pkg::ADC_W-1:0] ADC_DATA,
  output ccdr_pkg::ccdr_gates_t GATES,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output ccdr_pkg::ccdr_pix_t OUT_PIX
);
  typedef enum logic [2:0] {IDLE, PD_READ, VXFER, LSHIFT, SERIAL, WAIT} ccdr_st_t;
  localparam logic [19:0] FRAME_LAST = 20'(FRAME_CYC - 1);
  localparam logic [19:0] XFER_CYC = 20'(ccdr_pkg::XFER_CYC);
  localparam logic [10:0] LAST_COL = 11'(ccdr_pkg::LINE_PIX - 1);
  localparam logic [10:0] DARK_HI = 11'(ccdr_pkg::LINE_PIX - ccdr_pkg::DARK_RIGHT);
  localparam int A_PD = ccdr_pkg::PD_PULSE_CYC;

  ccdr_st_t st_ff, nxt_st;
  ccdr_pkg::ccdr_cfg_t cfg_ff, nxt_cfg;
  ccdr_pkg::ccdr_gates_t gate_ff, nxt_gate;
  logic [10:0] cnt_ff, nxt_cnt, col_ff, nxt_col;
  logic [9:0] line_ff, nxt_line;
  logic [19:0] tmr_ff, nxt_tmr, clear_at_ff, nxt_clear_at;
  logic [4:0] clr_ff, nxt_clr;
  logic ph_ff, nxt_ph;
  logic [ccdr_pkg::ADC_W-1:0] adc_s1_ff, adc_s2_ff;
  logic push, in_ready, keep, last_line;
  logic [9:0] first_kept;
  logic [15:0] exp_us;
  ccdr_pkg::ccdr_pix_t pix;

  // Output lines per frame include the two pipeline lines of the double-length register.
  function automatic logic [9:0] last_out(input logic il);
    last_out = il ? 10'(ccdr_pkg::STORE_ROWS / 2 + ccdr_pkg::DUMMY_LINES - 1)
                  : 10'(ccdr_pkg::STORE_ROWS + ccdr_pkg::DUMMY_LINES - 1);
  endfunction : last_out

  ////////////////////////////////////////////////////////////////////////////
  // ADC data arrives from pins, so it passes two flip-flops first.
  always_ff @(posedge CLK) begin
    if (RST) begin
      adc_s1_ff <= '0;
      adc_s2_ff <= '0;
    end else begin
      adc_s1_ff <= ADC_DATA;
      adc_s2_ff <= adc_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The first lines out are pipeline fill and then the shielded isolation lines.
  assign first_kept = cfg_ff.interlace ? 10'(ccdr_pkg::DUMMY_LINES + ccdr_pkg::ISO_LINES / 2)
                                       : 10'(ccdr_pkg::DUMMY_LINES + ccdr_pkg::ISO_LINES);
  assign keep = (line_ff >= first_kept);
  assign last_line = (line_ff == last_out(cfg_ff.interlace));
  assign exp_us = (EXPOSURE_US < 16'(ccdr_pkg::EXP_MIN_US)) ? 16'(ccdr_pkg::EXP_MIN_US) :
                  (EXPOSURE_US > 16'(ccdr_pkg::EXP_MAX_US)) ? 16'(ccdr_pkg::EXP_MAX_US) : EXPOSURE_US;

  always_comb begin
    nxt_st = st_ff;
    nxt_cfg = cfg_ff;
    nxt_cnt = cnt_ff;
    nxt_col = col_ff;
    nxt_line = line_ff;
    nxt_ph = ph_ff;
    nxt_clear_at = clear_at_ff;
    nxt_tmr = (tmr_ff == FRAME_LAST) ? tmr_ff : tmr_ff + 1'b1;
    nxt_clr = (clr_ff != '0) ? clr_ff - 1'b1 : clr_ff;
    nxt_gate = '0;
    nxt_gate.image_gate_b = ccdr_pkg::IGB_LOW;
    push = 1'b0;
    pix.frame_start = (line_ff == first_kept) && (col_ff == (cfg_ff.pix_sum ? 11'h001 : 11'h000));
    pix.line_end = (col_ff == LAST_COL);
    pix.dark = (col_ff < 11'(ccdr_pkg::DARK_LEFT)) || (col_ff >= DARK_HI);
    pix.data = adc_s2_ff;
    // Exposure starts at the clear pulse; skipped if it would hit the transfer.
    if (tmr_ff == clear_at_ff && clear_at_ff >= XFER_CYC && clr_ff == '0) begin
      nxt_clr = 5'(ccdr_pkg::PD_PULSE_CYC);
    end
    unique case (st_ff)
      IDLE: begin
        if (RUN) begin
          nxt_st = PD_READ;
        end
      end
      PD_READ: begin
        nxt_gate.image_gate_b = ccdr_pkg::IGB_HIGH;
        if (cnt_ff == '0) begin
          nxt_st = VXFER;
          nxt_cnt = 11'(2 * ccdr_pkg::STORE_ROWS - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      VXFER: begin
        // Image and storage gates step together at full clock rate.
        nxt_gate.image_gate_a = cnt_ff[0];
        nxt_gate.storage_gate_a = cnt_ff[0];
        nxt_gate.image_gate_b = cnt_ff[0] ? ccdr_pkg::IGB_LOW : ccdr_pkg::IGB_MID;
        nxt_gate.storage_gate_b = !cnt_ff[0];
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          nxt_st = LSHIFT;
          nxt_line = '0;
          nxt_cnt = cfg_ff.interlace ? 11'h003 : 11'h001;
        end
      end
      LSHIFT: begin
        // Two storage shifts in pseudo-interlace sum two lines in the register.
        nxt_gate.storage_gate_a = cnt_ff[0];
        nxt_gate.storage_gate_b = !cnt_ff[0];
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == '0) begin
          nxt_st = SERIAL;
          nxt_col = '0;
          nxt_ph = 1'b0;
        end
      end
      SERIAL: begin
        if (!ph_ff) begin
          nxt_gate.serial_gate_a = 1'b1;
          nxt_gate.reset_gate = !(cfg_ff.pix_sum && col_ff[0]);
          nxt_gate.sample_reset = nxt_gate.reset_gate;
          nxt_ph = 1'b1;
        end else begin
          nxt_gate.serial_gate_b = 1'b1;
          nxt_gate.multiplier_gate = cfg_ff.mult_en;
          nxt_gate.sample_signal = 1'b1;
          push = keep && (!cfg_ff.pix_sum || col_ff[0]);
          // Back-pressure freezes the serial clocks rather than dropping a pixel.
          if (!push || in_ready) begin
            nxt_ph = 1'b0;
            nxt_col = col_ff + 1'b1;
            if (col_ff == LAST_COL) begin
              nxt_line = line_ff + 1'b1;
              nxt_st = last_line ? WAIT : LSHIFT;
              nxt_cnt = cfg_ff.interlace ? 11'h003 : 11'h001;
            end
          end
        end
      end
      WAIT: begin
        if (tmr_ff == FRAME_LAST) begin
          nxt_st = RUN ? PD_READ : IDLE;
        end
      end
    endcase
    if (nxt_st == PD_READ && st_ff != PD_READ) begin
      // Mode and exposure are latched per frame.
      nxt_cnt = 11'(ccdr_pkg::PD_PULSE_CYC - 1);
      nxt_tmr = '0;
      nxt_clr = '0;
      nxt_cfg = '{interlace: INTERLACE, pix_sum: PIX_SUM, mult_en: MULT_EN};
      // The product needs 20 bits; a 16-bit multiply would wrap above about 3.3 ms.
      nxt_clear_at = 20'(FRAME_CYC) - 20'(exp_us) * 20'(ccdr_pkg::CYC_PER_US);
    end
    if (clr_ff != '0) begin
      nxt_gate.image_gate_b = ccdr_pkg::IGB_HIGH;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_ff <= IDLE;
      cfg_ff <= '0;
      gate_ff <= '0;
      cnt_ff <= '0;
      col_ff <= '0;
      line_ff <= '0;
      tmr_ff <= '0;
      clear_at_ff <= '0;
      clr_ff <= '0;
      ph_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cfg_ff <= nxt_cfg;
      gate_ff <= nxt_gate;
      cnt_ff <= nxt_cnt;
      col_ff <= nxt_col;
      line_ff <= nxt_line;
      tmr_ff <= nxt_tmr;
      clear_at_ff <= nxt_clear_at;
      clr_ff <= nxt_clr;
      ph_ff <= nxt_ph;
    end
  end

  assign GATES = gate_ff;

  ////////////////////////////////////////////////////////////////////////////
  ccdr_fifo #(.W($bits(ccdr_pkg::ccdr_pix_t)), .D(ccdr_pkg::FIFO_DEPTH)) u_fifo (
    .CLK(CLK),
    .RST(RST),
    .IN_VALID(push),
    .IN_READY(in_ready),
    .IN_DATA(pix),
    .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY),
    .OUT_DATA(OUT_PIX)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_pd_pulse_len: assert property ($rose(st_ff == PD_READ) |-> ##A_PD st_ff == VXFER)
    else $error("readout pulse length wrong");
  a_pd_gate_high: assert property (st_ff == PD_READ |=> gate_ff.image_gate_b == ccdr_pkg::IGB_HIGH)
    else $error("image_gate_b not high during readout pulse");
  a_vxfer_follows: assert property (st_ff == PD_READ && cnt_ff == '0 |=> st_ff == VXFER)
    else $error("storage transfer did not follow readout pulse");
  a_one_line_shift: assert property ($rose(st_ff == LSHIFT) && !cfg_ff.interlace |-> ##2 st_ff == SERIAL)
    else $error("progressive line shift not one line");
  a_two_line_shift: assert property ($rose(st_ff == LSHIFT) && cfg_ff.interlace |-> ##4 st_ff == SERIAL)
    else $error("interlace did not shift two lines");
  a_clear_outside_xfer: assert property (clr_ff != '0 |-> !(st_ff inside {PD_READ, VXFER}))
    else $error("clear pulse overlaps frame transfer");
  a_exposure_span: assert property (st_ff != IDLE |->
    int'(clear_at_ff) >= FRAME_CYC - ccdr_pkg::EXP_MAX_US * ccdr_pkg::CYC_PER_US &&
    int'(clear_at_ff) <= FRAME_CYC - ccdr_pkg::EXP_MIN_US * ccdr_pkg::CYC_PER_US)
    else $error("exposure outside allowed span");
  a_dummy_discard: assert property (push |-> line_ff >= 10'(ccdr_pkg::DUMMY_LINES))
    else $error("pipeline line pushed");
  a_reset_each_pix: assert property (st_ff == SERIAL && !ph_ff && !cfg_ff.pix_sum |=> gate_ff.reset_gate)
    else $error("reset gate missed a pixel");
  a_sum_skip_reset: assert property (st_ff == SERIAL && !ph_ff && cfg_ff.pix_sum && col_ff[0] |=> !gate_ff.reset_gate)
    else $error("reset gate not skipped while summing");
  a_cds_pair: assert property (gate_ff.sample_reset |=> gate_ff.sample_signal)
    else $error("signal sample did not follow reset sample");
  a_line_done_first: assert property (st_ff == SERIAL && nxt_st == LSHIFT |-> col_ff == LAST_COL)
    else $error("line shifted before serial readout ended");
  a_readout_first: assert property ($rose(st_ff == PD_READ) |-> $past(st_ff) inside {IDLE, WAIT})
    else $error("readout pulse before storage readout ended");

  c_frame_start: cover property (push && pix.frame_start);
  c_interlace_frame: cover property (cfg_ff.interlace && st_ff == WAIT);
  c_sum_push: cover property (push && cfg_ff.pix_sum);
  c_stall: cover property (st_ff == SERIAL && push && !in_ready);
endmodule : ccdr_ctrl
`default_nettype wire

// ---- rtl/ccdr_pkg.sv ----
/*
  Constants, types and geometry of the readout timing controller for a
  frame-interline-transfer imager with an in-register charge multiplier.
  Assumes a 20 MHz system clock and an external ADC on the sensor output.
*/
package ccdr_pkg;
  localparam int CLK_NS = 50;
  localparam int LINE_PIX = 680;
  localparam int LINES = 500;
  localparam int ISO_LINES = 4;
  localparam int DARK_LEFT = 20;
  localparam int DARK_RIGHT = 2;
  localparam int DUMMY_LINES = 2;
  localparam int STORE_ROWS = LINES + ISO_LINES;
  localparam int PD_PULSE_NS = 1000;
  localparam int PD_PULSE_CYC = (PD_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int XFER_CYC = PD_PULSE_CYC + 2 * STORE_ROWS;
  localparam int CYC_PER_US = 1000 / CLK_NS;
  localparam int EXP_MIN_US = 500;
  localparam int EXP_MAX_US = 33333;
  localparam int FRAME_NS = 33333333;
  localparam int FRAME_CYC = FRAME_NS / CLK_NS;
  localparam int ADC_W = 12;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {IGB_LOW, IGB_MID, IGB_HIGH} ccdr_lvl_t;

  typedef struct packed {
    logic image_gate_a;
    ccdr_lvl_t image_gate_b;
    logic storage_gate_a;
    logic storage_gate_b;
    logic serial_gate_a;
    logic serial_gate_b;
    logic multiplier_gate;
    logic reset_gate;
    logic sample_reset;
    logic sample_signal;
  } ccdr_gates_t;

  typedef struct packed {
    logic frame_start;
    logic line_end;
    logic dark;
    logic [ADC_W-1:0] data;
  } ccdr_pix_t;

  typedef struct packed {
    logic interlace;
    logic pix_sum;
    logic mult_en;
  } ccdr_cfg_t;
endpackage : ccdr_pkg

// ---- rtl/ccdr_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ccdr_fifo #(
  parameter int W = 15,
  parameter int D = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire logic [W-1:0] IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic [W-1:0] OUT_DATA
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [W-1:0] nxt_mem [D];
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign IN_READY = (cnt_ff != (AW+1)'(D));
  assign OUT_VALID = (cnt_ff != '0);
  assign OUT_DATA = mem_ff[rd_ff];
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr = wr_ff;
    nxt_rd = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ff] = IN_DATA;
      nxt_wr = (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rd = (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
    end
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge CLK) begin
    mem_ff <= nxt_mem;
    if (RST) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : ccdr_fifo
`default_nettype wire

// ---- tb/ccdr_sensor_model.sv ----
/*
  Behavioural imager for the readout bench: storage rows and a summing serial register.
  Assumes registered gate levels from the controller; its output feeds the ADC input directly.
*/
`timescale 1ns/10ps
`default_nettype none
module ccdr_sensor_model (
  input wire ccdr_pkg::ccdr_gates_t GATES,
  output logic [ccdr_pkg::ADC_W-1:0] ADC_DATA
);
  int shifts = 0;
  int acc = 0;
  bit read_out = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Image and storage gates stepping together load a new frame into storage; a clear pulse
  // alone leaves stored charge untouched. Row codes rise with the row, so a lost or repeated
  // line shift shows at the output. Isolation and pipeline rows are not special here.
  always @(posedge GATES.storage_gate_a) begin
    if (GATES.image_gate_a) begin
      shifts = 0;
      acc = 0;
      read_out = 1'b1;
    end else begin
      if (read_out) begin
        acc = 0;
      end
      read_out = 1'b0;
      shifts = shifts + 1;
      acc = acc + shifts * 3 + 16;
    end
  end

  always @(posedge GATES.serial_gate_a) begin
    read_out = 1'b1;
  end

  assign ADC_DATA = acc[ccdr_pkg::ADC_W-1:0];
endmodule : ccdr_sensor_model
`default_nettype wire

// ---- tb/ccdr_ctrl_test.sv ----
/*
  Self-checking bench for the readout controller: progressive run with FIFO fill and random
  stalls, then a mid-run reset into interlace with pixel summing.
  Assumes the sensor model drives the ADC input.
*/
`timescale 1ns/10ps
`default_nettype none
module ccdr_ctrl_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic interlace = 1'b0;
  logic pix_sum = 1'b0;
  logic mult_en = 1'b0;
  logic [15:0] exposure_us = 16'h01F4;
  logic [ccdr_pkg::ADC_W-1:0] adc_data;
  ccdr_pkg::ccdr_gates_t gates;
  ccdr_pkg::ccdr_gates_t held;
  ccdr_pkg::ccdr_pix_t out_pix;
  logic out_valid;
  logic out_ready = 1'b0;
  logic prev_sa = 1'b0;
  logic prev_ser = 1'b0;
  logic prev_rg = 1'b0;
  int fails = 0;
  int n_compared = 0;
  int seed = 19;
  int popped = 0;
  int ready_mode = 0;
  int pd_len = 0;
  int pix = 0;
  int rg = 0;
  int sh = 0;
  int pulses = 0;

  always #25 clk = ~clk;

  // A short frame puts the clear pulse inside the first readout, so exposure control is exercised.
  ccdr_ctrl #(.FRAME_CYC(11100)) uut (.CLK(clk), .RST(rst), .RUN(run), .INTERLACE(interlace),
    .PIX_SUM(pix_sum), .MULT_EN(mult_en), .EXPOSURE_US(exposure_us), .ADC_DATA(adc_data),
    .GATES(gates), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_PIX(out_pix));
  ccdr_sensor_model sensor (.GATES(gates), .ADC_DATA(adc_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // Word k of the kept stream; line codes follow the sensor model's row numbering.
  function automatic logic [14:0] exp_word(input int k);
    int n;
    int col;
    int j;
    int v;
    n = pix_sum ? 340 : 680;
    col = pix_sum ? 2 * (k % n) + 1 : k % n;
    j = (interlace ? 4 : 6) + k / n;
    v = interlace ? 12 * j + 41 : 3 * j + 19;
    return {k == 0, col == 679, col < 20 || col >= 678, v[11:0]};
  endfunction : exp_word

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    // Ready settles before the pop test, so both use the value the next rising edge samples.
    out_ready = ready_mode == 2 || (ready_mode == 1 && ($random(seed) & 1));
    if (rst) begin
      pd_len = 0;
      pulses = 0;
      pix = 0;
      rg = 0;
      sh = 0;
    end else begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        check("pixel word", out_pix, exp_word(popped));
        popped++;
      end
      if (gates.image_gate_b == ccdr_pkg::IGB_HIGH) begin
        pd_len++;
      end else if (pd_len > 0) begin
        check("photodiode pulse length", pd_len, 20);
        pd_len = 0;
        pulses++;
      end
      if (gates.serial_gate_b) begin
        check("multiplier gate", gates.multiplier_gate, mult_en);
      end
      check("shift during serial", (gates.storage_gate_a | gates.storage_gate_b)
        & (gates.serial_gate_a | gates.serial_gate_b), 0);
      if (gates.storage_gate_a && !prev_sa && !gates.image_gate_a) begin
        if (pix > 0) begin
          check("pixels per line", pix, 680);
          check("reset pulses per line", rg, pix_sum ? 340 : 680);
        end
        pix = 0;
        rg = 0;
        sh++;
      end
      if (gates.serial_gate_a && !prev_ser) begin
        if (sh > 0) begin
          check("shifts per line", sh, interlace ? 2 : 1);
        end
        sh = 0;
        pix++;
      end
      if (gates.reset_gate && !prev_rg) begin
        rg++;
      end
    end
    prev_sa = gates.storage_gate_a;
    prev_ser = gates.serial_gate_a;
    prev_rg = gates.reset_gate;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic start_run(input logic il, input logic ps, input logic me);
    rst = 1'b1;
    run = 1'b0;
    ready_mode = 0;
    repeat (6) @(negedge clk);
    check("gates in reset", gates, 0);
    check("valid in reset", out_valid, 0);
    interlace = il;
    pix_sum = ps;
    mult_en = me;
    popped = 0;
    rst = 1'b0;
    @(negedge clk);
    run = 1'b1;
  endtask : start_run

  task automatic wait_words(input int count);
    for (int i = 0; i < 40000 && popped < count; i++) @(negedge clk);
    check("words delivered", popped >= count, 1);
    check("readout and clear pulses", pulses, 2);
  endtask : wait_words

  initial begin
    start_run(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 20000 && out_valid !== 1'b1; i++) @(negedge clk);
    // With the sink stalled the FIFO fills within some 32 cycles and the sequencer must wait.
    repeat (100) @(negedge clk);
    held = gates;
    check("strobe while full", gates.sample_signal, 1);
    repeat (20) begin
      @(negedge clk);
      check("gates while full", gates, held);
    end
    ready_mode = 1;
    wait_words(1360);
    start_run(1'b1, 1'b1, 1'b0);
    ready_mode = 1;
    wait_words(680);
    stop_test();
  end

  initial begin
    #5000000;
    fails++;
    stop_test();
  end
endmodule : ccdr_ctrl_test
`default_nettype wire
